// >>> pmbp_consts.vh
// Purpose: constants for the program memory block protection logic
// Assumes: 22-bit table pointer, byte-wide configuration registers
// Notes:   configuration bits erase to one, program to zero
`ifndef PMBP_CONSTS_VH
`define PMBP_CONSTS_VH

// ----------------------------------------
// addresses
// ----------------------------------------
`define PMBP_BOOT_BYTES      22'h000200
`define PMBP_BLK0_BASE       22'h000200
`define PMBP_BLK1_BASE       22'h002000
`define PMBP_BLK2_BASE       22'h004000
`define PMBP_BLK3_BASE       22'h006000
`define PMBP_MEM_END         22'h008000
`define PMBP_ID_FIRST        22'h200000
`define PMBP_ID_LAST         22'h200007
`define PMBP_DEVID_LO        22'h3ffffe
`define PMBP_DEVID_HI        22'h3fffff
`define PMBP_CFG_FIRST       22'h300000
`define PMBP_CFG_LAST        22'h30000d
`define PMBP_CP_BLOCKS       22'h300008
`define PMBP_CP_BOOT_EE      22'h300009
`define PMBP_WP_BLOCKS       22'h30000a
`define PMBP_WP_BOOT_EE_CFG  22'h30000b
`define PMBP_ERP_BLOCKS      22'h30000c
`define PMBP_ERP_BOOT        22'h30000d
`define PMBP_DBG_LVP_CFG     22'h300006

// ----------------------------------------
// field positions
// ----------------------------------------
`define PMBP_BIT_EE_CP       7
`define PMBP_BIT_BOOT_CP     6
`define PMBP_BIT_EE_WP       7
`define PMBP_BIT_BOOT_WP     6
`define PMBP_BIT_CFG_WP      5
`define PMBP_BIT_BOOT_ERP    6
`define PMBP_BIT_LVP         2
`define PMBP_BIT_DEBUG       7

// ----------------------------------------
// erased values and masks
// ----------------------------------------
`define PMBP_BLK_MASK        8'h0f
`define PMBP_CP_BOOT_MASK    8'hc0
`define PMBP_WP_HI_MASK      8'he0
`define PMBP_ERP_BOOT_MASK   8'h40
`define PMBP_DBG_LVP_MASK    8'h84
`define PMBP_NUM_BLOCKS      4
`define PMBP_NUM_IDS         8

`endif

// >>> pmbp_id_mem.v
// Purpose: eight-byte user identification store
// Assumes: one write or one read per cycle
// Notes:   read data registered
`timescale 1ns/10ps
module pmbp_id_mem (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// access
	input  wire       wr_en,
	input  wire [2:0] addr,
	input  wire [7:0] wr_data,
	output reg  [7:0] rd_data
);

	reg [7:0] mem_reg [0:7];
	integer   i;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < 8; i = i + 1) begin
				mem_reg[i] <= 8'hff;
			end
			rd_data <= 8'h00;
		end else begin
			if (wr_en) begin
				mem_reg[addr] <= wr_data;
			end
			rd_data <= mem_reg[addr];
		end
	end

endmodule // pmbp_id_mem

// >>> pmbp_pmem_model.sv
// Purpose: program array model behind the table access gate
// Assumes: read data combinational from the address
// Notes:   space above the array gives the inverted low address byte, zero where that byte is ff
`timescale 1ns/10ps
module pmbp_pmem_model (
	// array side
	input  wire [21:0] pmem_addr,
	output wire [7:0]  pmem_rd_data
);
	assign pmem_rd_data = (pmem_addr < 22'h008000) ? (pmem_addr[7:0] ^ 8'h3c) : ~pmem_addr[7:0];
endmodule // pmbp_pmem_model

// >>> pmbp_protect.v
// Purpose: table access gating and protection configuration store
// Assumes: program array outside, id store inside; one table op per cycle; programmer pins async
// Notes:   table latch answers two cycles after a read request
`timescale 1ns/10ps
`include "pmbp_consts.vh"
module pmbp_protect (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// cpu table access
	input  wire        table_read_op,
	input  wire        table_write_op,
	input  wire [21:0] table_pointer,
	input  wire [21:0] cpu_pc,
	input  wire [7:0]  table_wr_data,
	output reg  [7:0]  table_latch,
	// external program memory array
	output reg         pmem_rd_en,
	output reg         pmem_wr_en,
	output reg  [21:0] pmem_addr,
	output reg  [7:0]  pmem_wr_data,
	input  wire [7:0]  pmem_rd_data,
	input  wire [7:0]  devid_data,
	// programmer side
	input  wire        ext_prog_active,
	input  wire        ext_read,
	input  wire        ext_write,
	input  wire        ext_is_eeprom,
	input  wire [21:0] ext_addr,
	output reg         ext_allow,
	input  wire        ext_chip_erase,
	input  wire        ext_block_erase,
	input  wire [2:0]  ext_erase_block,
	// eeprom gating
	input  wire        cpu_eeprom_req,
	output wire        cpu_eeprom_allow,
	// mode pins
	input  wire        master_clear_pin,
	input  wire        prog_mode_pin,
	input  wire        hv_detect,
	output wire        prog_mode_entry,
	output wire        prog_pin_pullup_en,
	output wire        prog_pin_is_io,
	// debugger
	output wire        debug_enable,
	// small parts
	input  wire        large_part
);

	reg  [7:0] cp_blk_reg;
	reg  [7:0] cp_be_reg;
	reg  [7:0] wp_blk_reg;
	reg  [7:0] wp_hi_reg;
	reg  [7:0] erp_blk_reg;
	reg  [7:0] erp_boot_reg;
	reg  [7:0] dbg_lvp_reg;
	reg  [1:0] mclr_sync_reg;
	reg  [1:0] pgm_sync_reg;
	reg  [1:0] hv_sync_reg;
	reg        hv_entry_reg;
	reg        rd_id_reg;
	reg        rd_mem_reg;
	reg        rd_zero_reg;
	reg        rd_devid_reg;
	reg        rd_cfg_reg;
	reg  [7:0] cfg_rd_reg;
	wire [7:0] id_rd_data;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// boot block index 4
	function [2:0] blk_of;
		input [21:0] a;
		begin
			if (a < `PMBP_BOOT_BYTES)
				blk_of = 3'd4;
			else if (a < `PMBP_BLK1_BASE)
				blk_of = 3'd0;
			else if (a < `PMBP_BLK2_BASE)
				blk_of = 3'd1;
			else if (a < `PMBP_BLK3_BASE)
				blk_of = 3'd2;
			else
				blk_of = 3'd3;
		end
	endfunction

	function in_mem;
		input [21:0] a;
		input        big;
		begin
			in_mem = big ? (a < `PMBP_MEM_END) : (a < `PMBP_BLK2_BASE);
		end
	endfunction

	function is_id;
		input [21:0] a;
		begin
			is_id = (a >= `PMBP_ID_FIRST) && (a <= `PMBP_ID_LAST);
		end
	endfunction

	function is_cfg;
		input [21:0] a;
		begin
			is_cfg = (a >= `PMBP_CFG_FIRST) && (a <= `PMBP_CFG_LAST);
		end
	endfunction

	// per-block bit vectors, boot at index 4
	wire [4:0] wp_vec  = {wp_hi_reg[`PMBP_BIT_BOOT_WP], wp_blk_reg[3:0]};
	wire [4:0] erp_vec = {erp_boot_reg[`PMBP_BIT_BOOT_ERP], erp_blk_reg[3:0]};
	wire [4:0] cp_vec  = {cp_be_reg[`PMBP_BIT_BOOT_CP], cp_blk_reg[3:0]};

	wire [2:0] tp_blk  = blk_of(table_pointer);
	wire [2:0] pc_blk  = blk_of(cpu_pc);
	wire       tp_mem  = in_mem(table_pointer, large_part);
	wire       tp_id   = is_id(table_pointer);
	wire       tp_cfg  = is_cfg(table_pointer);
	wire       tp_dev  = (table_pointer == `PMBP_DEVID_LO) || (table_pointer == `PMBP_DEVID_HI);
	wire       cfg_wp  = ~wp_hi_reg[`PMBP_BIT_CFG_WP];

	// inside block or bit set lets the read through
	wire rd_ok = erp_vec[tp_blk] | (pc_blk == tp_blk);
	wire wr_ok = wp_vec[tp_blk];
	wire ext_ok_hv = hv_entry_reg;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mclr_sync_reg <= 2'b00;
			pgm_sync_reg  <= 2'b00;
			hv_sync_reg   <= 2'b00;
		end else begin
			mclr_sync_reg <= {mclr_sync_reg[0], master_clear_pin};
			pgm_sync_reg  <= {pgm_sync_reg[0], prog_mode_pin};
			hv_sync_reg   <= {hv_sync_reg[0], hv_detect};
		end
	end

	// ----------------------------------------
	// programming entry
	// ----------------------------------------
	wire lvp_en = dbg_lvp_reg[`PMBP_BIT_LVP];
	wire hv_entry = mclr_sync_reg[1] & hv_sync_reg[1];
	// low voltage entry via mode pin
	wire lv_entry = lvp_en & pgm_sync_reg[1];
	assign prog_mode_entry = hv_entry | lv_entry;
	assign prog_pin_pullup_en = ~lvp_en;
	// cleared bit returns pin to io
	assign prog_pin_is_io = ~lvp_en;
	assign debug_enable = ~dbg_lvp_reg[`PMBP_BIT_DEBUG];
	assign cpu_eeprom_allow = cpu_eeprom_req;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hv_entry_reg <= 1'b0;
		else
			hv_entry_reg <= hv_entry;
	end

	// ----------------------------------------
	// external programmer gating
	// ----------------------------------------
	// code protect acts only here
	always @* begin
		ext_allow = 1'b0;
		if (ext_prog_active) begin
			if (ext_is_eeprom)
				ext_allow = cp_be_reg[`PMBP_BIT_EE_CP] &
				            (ext_read | wp_hi_reg[`PMBP_BIT_EE_WP]);
			else if (is_id(ext_addr) || is_cfg(ext_addr))
				ext_allow = 1'b1;
			else if (in_mem(ext_addr, large_part))
				ext_allow = cp_vec[blk_of(ext_addr)] &
				            (ext_read | wp_vec[blk_of(ext_addr)]);
		end
	end

	// ----------------------------------------
	// configuration store
	// ----------------------------------------
	wire cpu_cfg_wr = table_write_op & tp_cfg & ~cfg_wp;
	wire ext_cfg_wr = ext_prog_active & ext_write & is_cfg(ext_addr);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_blk_reg   <= `PMBP_BLK_MASK;
			cp_be_reg    <= `PMBP_CP_BOOT_MASK;
			wp_blk_reg   <= `PMBP_BLK_MASK;
			wp_hi_reg    <= `PMBP_WP_HI_MASK;
			erp_blk_reg  <= `PMBP_BLK_MASK;
			erp_boot_reg <= `PMBP_ERP_BOOT_MASK;
			dbg_lvp_reg  <= `PMBP_DBG_LVP_MASK;
		end else if (ext_prog_active && ext_chip_erase) begin
			cp_blk_reg   <= `PMBP_BLK_MASK;
			cp_be_reg    <= `PMBP_CP_BOOT_MASK;
			wp_blk_reg   <= `PMBP_BLK_MASK;
			wp_hi_reg    <= `PMBP_WP_HI_MASK;
			erp_blk_reg  <= `PMBP_BLK_MASK;
			erp_boot_reg <= `PMBP_ERP_BOOT_MASK;
			dbg_lvp_reg  <= `PMBP_DBG_LVP_MASK;
		end else if (ext_prog_active && ext_block_erase) begin
			if (ext_erase_block == 3'd4) begin
				cp_be_reg[`PMBP_BIT_BOOT_CP]     <= 1'b1;
				wp_hi_reg[`PMBP_BIT_BOOT_WP]     <= 1'b1;
				erp_boot_reg[`PMBP_BIT_BOOT_ERP] <= 1'b1;
			end else if (ext_erase_block < 3'd4) begin
				cp_blk_reg[ext_erase_block[1:0]]  <= 1'b1;
				wp_blk_reg[ext_erase_block[1:0]]  <= 1'b1;
				erp_blk_reg[ext_erase_block[1:0]] <= 1'b1;
			end
		end else if (cpu_cfg_wr || ext_cfg_wr) begin
			case (ext_cfg_wr ? ext_addr : table_pointer)
			`PMBP_CP_BLOCKS:
				cp_blk_reg <= cp_blk_reg & (table_wr_data | ~`PMBP_BLK_MASK);
			`PMBP_CP_BOOT_EE:
				cp_be_reg <= cp_be_reg & (table_wr_data | ~`PMBP_CP_BOOT_MASK);
			`PMBP_WP_BLOCKS:
				wp_blk_reg <= wp_blk_reg & (table_wr_data | ~`PMBP_BLK_MASK);
			`PMBP_WP_BOOT_EE_CFG: begin
				// user mode cannot touch config protect
				if (ext_cfg_wr)
					wp_hi_reg <= wp_hi_reg & (table_wr_data | ~`PMBP_WP_HI_MASK);
				else
					wp_hi_reg <= wp_hi_reg & (table_wr_data | 8'h20);
			end
			`PMBP_ERP_BLOCKS:
				erp_blk_reg <= erp_blk_reg & (table_wr_data | ~`PMBP_BLK_MASK);
			`PMBP_ERP_BOOT:
				erp_boot_reg <= erp_boot_reg & (table_wr_data | ~`PMBP_ERP_BOOT_MASK);
			`PMBP_DBG_LVP_CFG: begin
				// lvp clears only under high voltage entry
				if (ext_cfg_wr && ext_ok_hv)
					dbg_lvp_reg <= dbg_lvp_reg & (table_wr_data | ~`PMBP_DBG_LVP_MASK);
				else
					dbg_lvp_reg <= dbg_lvp_reg & (table_wr_data | 8'h04 | ~`PMBP_DBG_LVP_MASK);
			end
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// config read mux
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rd_reg <= 8'h00;
		end else begin
			case (table_pointer)
			`PMBP_CP_BLOCKS:      cfg_rd_reg <= cp_blk_reg;
			`PMBP_CP_BOOT_EE:     cfg_rd_reg <= cp_be_reg;
			`PMBP_WP_BLOCKS:      cfg_rd_reg <= wp_blk_reg;
			`PMBP_WP_BOOT_EE_CFG: cfg_rd_reg <= wp_hi_reg;
			`PMBP_ERP_BLOCKS:     cfg_rd_reg <= erp_blk_reg;
			`PMBP_ERP_BOOT:       cfg_rd_reg <= erp_boot_reg;
			`PMBP_DBG_LVP_CFG:    cfg_rd_reg <= dbg_lvp_reg;
			default:              cfg_rd_reg <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// table path to memory
	// ----------------------------------------
	// id bytes always reachable
	pmbp_id_mem u_id (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (table_write_op & tp_id),
		.addr    (table_pointer[2:0]),
		.wr_data (table_wr_data),
		.rd_data (id_rd_data)
	);

	// memory, config, id and device id reachable
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pmem_rd_en   <= 1'b0;
			pmem_wr_en   <= 1'b0;
			pmem_addr    <= 22'h000000;
			pmem_wr_data <= 8'h00;
			rd_id_reg    <= 1'b0;
			rd_mem_reg   <= 1'b0;
			rd_zero_reg  <= 1'b0;
			rd_devid_reg <= 1'b0;
			rd_cfg_reg   <= 1'b0;
		end else begin
			pmem_rd_en <= table_read_op & tp_mem & rd_ok;
			pmem_wr_en <= table_write_op & tp_mem & wr_ok;
			if (table_read_op || table_write_op)
				pmem_addr <= table_pointer;
			if (table_write_op && tp_mem && wr_ok)
				pmem_wr_data <= table_wr_data;
			rd_id_reg    <= table_read_op & tp_id;
			rd_mem_reg   <= table_read_op & tp_mem & rd_ok;
			rd_zero_reg  <= table_read_op & ~(tp_id | tp_cfg | tp_dev | (tp_mem & rd_ok));
			rd_devid_reg <= table_read_op & tp_dev;
			rd_cfg_reg   <= table_read_op & tp_cfg;
		end
	end

	// ----------------------------------------
	// table latch
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			table_latch <= 8'h00;
		else if (rd_mem_reg)
			table_latch <= pmem_rd_data;
		else if (rd_id_reg)
			table_latch <= id_rd_data;
		else if (rd_devid_reg)
			table_latch <= devid_data;
		else if (rd_cfg_reg)
			table_latch <= cfg_rd_reg;
		else if (rd_zero_reg)
			table_latch <= 8'h00;
	end

endmodule // pmbp_protect

// >>> pmbp_protect_sva.sv
// Purpose: port checker for the protection gate
// Assumes: one clock domain
// Notes:   bound to every instance
`timescale 1ns/10ps
module pmbp_protect_sva (
	// clock and reset
	input wire        clk,
	input wire        rst_n,
	// watched ports
	input wire        table_read_op,
	input wire        table_write_op,
	input wire [21:0] table_pointer,
	input wire [7:0]  table_wr_data,
	input wire [7:0]  table_latch,
	input wire        pmem_rd_en,
	input wire        pmem_wr_en,
	input wire [21:0] pmem_addr,
	input wire [7:0]  pmem_wr_data,
	input wire        cpu_eeprom_req,
	input wire        cpu_eeprom_allow,
	input wire        master_clear_pin,
	input wire        prog_mode_pin,
	input wire        hv_detect,
	input wire        prog_mode_entry,
	input wire        prog_pin_pullup_en,
	input wire        prog_pin_is_io
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_source_a: assert property (pmem_rd_en |-> $past(table_read_op)
		&& pmem_addr == $past(table_pointer)) else $error("array read without request");
	wr_source_a: assert property (pmem_wr_en |-> $past(table_write_op)
		&& pmem_addr == $past(table_pointer) && pmem_wr_data == $past(table_wr_data))
		else $error("array write without matching request");
	unimpl_zero_a: assert property ($past(table_read_op, 2) && $past(table_pointer, 2) >= 22'h008000
		&& $past(table_pointer, 2) < 22'h200000 |-> table_latch == 8'h00)
		else $error("unimplemented space read non-zero");
	latch_hold_a: assert property (!$past(table_read_op, 2) |-> $stable(table_latch))
		else $error("table latch changed without read");
	eeprom_cpu_a: assert property (cpu_eeprom_allow == cpu_eeprom_req)
		else $error("cpu eeprom access gated");
	pin_pair_a: assert property (prog_pin_pullup_en == prog_pin_is_io)
		else $error("pull-up and io mode disagree");
	lvp_entry_a: assert property ($past(prog_mode_pin, 2) && !prog_pin_is_io
		&& !$past(prog_pin_is_io) |-> prog_mode_entry) else $error("low voltage entry missed");
	hv_entry_a: assert property ($past(master_clear_pin, 2) && $past(hv_detect, 2)
		|-> prog_mode_entry) else $error("high voltage entry missed");
	io_no_entry_a: assert property (prog_pin_is_io && $past(prog_pin_is_io, 2)
		&& !$past(master_clear_pin, 2) |-> !prog_mode_entry) else $error("io pin entered mode");
	cover property (pmem_wr_en);
	cover property (prog_mode_entry && prog_pin_is_io);
	cover property ($past(table_read_op, 2) && table_latch == 8'h00);
endmodule // pmbp_protect_sva
bind pmbp_protect pmbp_protect_sva u_pmbp_protect_sva (.clk, .rst_n, .table_read_op,
	.table_write_op, .table_pointer, .table_wr_data, .table_latch, .pmem_rd_en, .pmem_wr_en,
	.pmem_addr, .pmem_wr_data, .cpu_eeprom_req, .cpu_eeprom_allow, .master_clear_pin,
	.prog_mode_pin, .hv_detect, .prog_mode_entry, .prog_pin_pullup_en, .prog_pin_is_io);

// >>> pmbp_protect_test.sv
// Purpose: self-checking bench for the protection gate
// Assumes: array model answers combinationally
// Notes:   device id byte value is arbitrary
`timescale 1ns/10ps
module pmbp_protect_test;
	reg         clk, rst_n, table_read_op, table_write_op, ext_prog_active, ext_read;
	reg         ext_write, ext_is_eeprom, ext_chip_erase, ext_block_erase, cpu_eeprom_req;
	reg         master_clear_pin, prog_mode_pin, hv_detect, large_part;
	reg  [21:0] table_pointer, cpu_pc, ext_addr;
	reg  [7:0]  table_wr_data;
	reg  [2:0]  ext_erase_block;
	wire [7:0]  table_latch, pmem_wr_data, pmem_rd_data;
	wire [21:0] pmem_addr;
	wire        pmem_rd_en, pmem_wr_en, ext_allow, cpu_eeprom_allow, prog_mode_entry;
	wire        prog_pin_pullup_en, prog_pin_is_io, debug_enable;
	integer     n_errors, n_tests, i;
	localparam [7:0]  DEVID = 8'h5a; // arbitrary value
	localparam [47:0] RV = 48'h0fc00fe00f40;
	pmbp_protect u_pmbp_protect (.clk, .rst_n, .table_read_op, .table_write_op, .table_pointer,
		.cpu_pc, .table_wr_data, .table_latch, .pmem_rd_en, .pmem_wr_en, .pmem_addr,
		.pmem_wr_data, .pmem_rd_data, .devid_data(DEVID), .ext_prog_active, .ext_read,
		.ext_write, .ext_is_eeprom, .ext_addr, .ext_allow, .ext_chip_erase, .ext_block_erase,
		.ext_erase_block, .cpu_eeprom_req, .cpu_eeprom_allow, .master_clear_pin,
		.prog_mode_pin, .hv_detect, .prog_mode_entry, .prog_pin_pullup_en, .prog_pin_is_io,
		.debug_enable, .large_part);
	pmbp_pmem_model u_pmbp_pmem_model (.pmem_addr, .pmem_rd_data);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [7:0] pat(input [21:0] a);
		pat = a[7:0] ^ 8'h3c;
	endfunction
	task cmp(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task cmpb(input got, input exp);
		cmp({7'h00, got}, {7'h00, exp});
	endtask
	task rd(input [21:0] a, input [21:0] pc, input [7:0] exp);
		begin
			@(posedge clk);
			table_read_op <= 1'b1;
			table_pointer <= a;
			cpu_pc <= pc;
			@(posedge clk);
			table_read_op <= 1'b0;
			repeat (2) @(posedge clk);
			#1 cmp(table_latch, exp);
		end
	endtask
	task wr(input [21:0] a, input [7:0] d, input chk, input strobe);
		begin
			@(posedge clk);
			table_write_op <= 1'b1;
			table_pointer <= a;
			table_wr_data <= d;
			@(posedge clk);
			table_write_op <= 1'b0;
			#1 if (chk) cmpb(pmem_wr_en, strobe);
			@(posedge clk);
		end
	endtask
	task ext(input ee, input r, input [21:0] a, input exp);
		begin
			@(posedge clk);
			ext_prog_active <= 1'b1;
			ext_is_eeprom <= ee;
			ext_read <= r;
			ext_write <= !r;
			ext_addr <= a;
			#1 cmpb(ext_allow, exp);
		end
	endtask
	task pw(input [21:0] a, input [7:0] d);
		begin
			ext(1'b0, 1'b0, a, 1'b1);
			table_wr_data <= d;
			repeat (2) @(posedge clk);
			ext_write <= 1'b0;
			ext_prog_active <= 1'b0;
		end
	endtask
	task pulse(input chip, input [2:0] blk);
		begin
			@(posedge clk);
			ext_prog_active <= 1'b1;
			ext_chip_erase <= chip;
			ext_block_erase <= !chip;
			ext_erase_block <= blk;
			@(posedge clk);
			ext_chip_erase <= 1'b0;
			ext_block_erase <= 1'b0;
			ext_prog_active <= 1'b0;
		end
	endtask
	task chk_cfg;
		begin
			for (i = 0; i < 6; i = i + 1)
				rd(22'h300008 + i, 22'h0, RV[47 - 8 * i -: 8]);
			rd(22'h300006, 22'h0, 8'h84);
			cmpb(debug_enable, 1'b0);
			cmpb(prog_pin_is_io, 1'b0);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_map;
		begin
			rd(22'h000010, 22'h000010, pat(22'h000010));
			rd(22'h003456, 22'h0, pat(22'h003456));
			rd(22'h3ffffe, 22'h0, DEVID);
			rd(22'h200003, 22'h0, 8'hff);
			wr(22'h200003, 8'h55, 1'b0, 1'b0);
			rd(22'h200003, 22'h0, 8'h55);
			rd(22'h008000, 22'h0, 8'h00);
			@(posedge clk) large_part <= 1'b0;
			rd(22'h004100, 22'h0, 8'h00);
			rd(22'h007ff0, 22'h0, 8'h00);
			@(posedge clk) large_part <= 1'b1;
			rd(22'h004100, 22'h0, pat(22'h004100));
			$display("done map");
		end
	endtask
	task t_wp;
		begin
			wr(22'h000300, 8'h11, 1'b1, 1'b1);
			wr(22'h30000a, 8'h0e, 1'b0, 1'b0);
			wr(22'h30000a, 8'h0f, 1'b0, 1'b0);
			rd(22'h30000a, 22'h0, 8'h0e);
			wr(22'h000300, 8'h11, 1'b1, 1'b0);
			cmp(table_latch, 8'h0e);
			wr(22'h002000, 8'h22, 1'b1, 1'b1);
			$display("done write protect");
		end
	endtask
	task t_erp;
		begin
			wr(22'h30000c, 8'h0d, 1'b0, 1'b0);
			rd(22'h002100, 22'h000400, 8'h00);
			rd(22'h002100, 22'h002500, pat(22'h002100));
			wr(22'h30000d, 8'h00, 1'b0, 1'b0);
			rd(22'h30000d, 22'h0, 8'h00);
			rd(22'h000010, 22'h000300, 8'h00);
			rd(22'h000010, 22'h000100, pat(22'h000010));
			$display("done read protect");
		end
	endtask
	task t_cp;
		begin
			wr(22'h300008, 8'h0e, 1'b0, 1'b0);
			rd(22'h000400, 22'h002000, pat(22'h000400));
			rd(22'h200001, 22'h0, 8'hff);
			ext(1'b0, 1'b1, 22'h000400, 1'b0);
			ext(1'b0, 1'b1, 22'h002400, 1'b1);
			ext(1'b1, 1'b0, 22'h0, 1'b1);
			wr(22'h30000b, 8'h7f, 1'b0, 1'b0);
			ext(1'b1, 1'b0, 22'h0, 1'b0);
			ext(1'b1, 1'b1, 22'h0, 1'b1);
			wr(22'h300009, 8'h7f, 1'b0, 1'b0);
			ext(1'b1, 1'b1, 22'h0, 1'b0);
			@(posedge clk) cpu_eeprom_req <= 1'b1;
			#1 cmpb(cpu_eeprom_allow, 1'b1);
			ext_prog_active <= 1'b0;
			wr(22'h30000b, 8'h00, 1'b0, 1'b0);
			rd(22'h30000b, 22'h0, 8'h20);
			wr(22'h000020, 8'h33, 1'b1, 1'b0);
			pulse(1'b0, 3'd0);
			rd(22'h30000a, 22'h0, 8'h0f);
			rd(22'h300008, 22'h0, 8'h0f);
			$display("done code protect");
		end
	endtask
	task t_lvp;
		begin
			wr(22'h300006, 8'h04, 1'b0, 1'b0);
			cmpb(debug_enable, 1'b1);
			@(posedge clk) prog_mode_pin <= 1'b1;
			repeat (4) @(posedge clk);
			cmpb(prog_mode_entry, 1'b1);
			prog_mode_pin <= 1'b0;
			wr(22'h300006, 8'h00, 1'b0, 1'b0);
			pw(22'h300006, 8'h00);
			rd(22'h300006, 22'h0, 8'h04);
			@(posedge clk) master_clear_pin <= 1'b1;
			hv_detect <= 1'b1;
			repeat (4) @(posedge clk);
			cmpb(prog_mode_entry, 1'b1);
			pw(22'h300006, 8'h00);
			rd(22'h300006, 22'h0, 8'h00);
			cmpb(prog_pin_pullup_en, 1'b1);
			master_clear_pin <= 1'b0;
			hv_detect <= 1'b0;
			prog_mode_pin <= 1'b1;
			repeat (4) @(posedge clk);
			cmpb(prog_mode_entry, 1'b0);
			prog_mode_pin <= 1'b0;
			pulse(1'b1, 3'd0);
			chk_cfg;
			$display("done low voltage and erase");
		end
	endtask
	task print_verdict;
		begin
			$display("counts: tests=%0d errors=%0d", n_tests, n_errors);
			if (n_errors == 0 && n_tests > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// ----------------------------------------
	// run
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		n_errors = n_errors + 1;
		print_verdict;
	end
	initial begin
		{rst_n, table_read_op, table_write_op, ext_prog_active, ext_read, ext_write} = 6'h00;
		{ext_is_eeprom, ext_chip_erase, ext_block_erase, cpu_eeprom_req} = 4'h0;
		{master_clear_pin, prog_mode_pin, hv_detect} = 3'h0;
		large_part = 1'b1;
		{table_pointer, cpu_pc, ext_addr} = 66'h0;
		table_wr_data = 8'h00;
		ext_erase_block = 3'h0;
		n_errors = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_cfg;
		$display("done reset values");
		t_map;
		t_wp;
		t_erp;
		t_cp;
		t_lvp;
		print_verdict;
	end
endmodule // pmbp_protect_test
